// ---- rtl/cuod_top.sv ----
// Purpose: Command-unit opcode decoder and command-unit state keeper
// Assumes: Host writes command word and general pointer synchronously
// Notes:   Commands wait in the command byte while a dump is running
`timescale 1ns/1ps
`default_nettype none
module cuod_top #(
    parameter int N_CNT = cuod_pkg::N_CNT_DEF
) (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  CMD_WR,
    input  wire logic [31:0]           CMD_WORD,
    input  wire logic                  GP_WR,
    input  wire logic [cuod_pkg::GP_W-1:0] GP_WDATA,
    input  wire logic                  CB_SUSPEND,
    input  wire logic                  CB_IDLE,
    input  wire logic [N_CNT*32-1:0]   STAT_CNT,
    input  wire logic                  MEM_READY,
    output logic [7:0]                 CMD_BYTE,
    output logic [cuod_pkg::GP_W-1:0]  GP_VALUE,
    output logic [1:0]                 CU_STATE,
    output logic                       CB_START,
    output logic                       CB_RESUME,
    output logic [cuod_pkg::GP_W-1:0]  CB_ADDR,
    output logic [cuod_pkg::GP_W-1:0]  CU_BASE,
    output logic [cuod_pkg::GP_W-1:0]  DUMP_ADDR,
    output logic                       DUMP_BUSY,
    output logic                       MEM_VALID,
    output logic [31:0]                MEM_ADDR,
    output logic [31:0]                MEM_WDATA,
    output logic                       STAT_CLR,
    output logic                       DUMP_DONE
);
    logic [7:0]                 cmd_q;
    logic [cuod_pkg::GP_W-1:0]  gp_q;
    logic [cuod_pkg::GP_W-1:0]  base_q;
    logic [cuod_pkg::GP_W-1:0]  dump_addr_q;
    logic [cuod_pkg::GP_W-1:0]  cb_addr_q;
    logic                       start_q;
    logic                       resume_q;
    cuod_pkg::cuod_cu_state_t   cu_q;
    cuod_pkg::cuod_cu_state_t   cu_d;
    logic [3:0]                 op;
    logic                       acc;
    logic                       dump_go;
    logic                       dump_busy;
    logic                       wake;

    assign op      = cmd_q[cuod_pkg::FLD_HI:cuod_pkg::FLD_LO];
    // A dump holds off further commands; they stay pending in the byte
    assign acc     = (op != cuod_pkg::OP_NOP) && !dump_busy;
    assign dump_go = acc && (op == cuod_pkg::OP_DUMP || op == cuod_pkg::OP_DUMP_CLR);
    assign wake    = (cu_q != cuod_pkg::CU_IDLE);

    // Command byte; a host write in the clearing cycle wins
    always_ff @(posedge CLK)
    begin
        if (RST)
            cmd_q <= cuod_pkg::CMD_RST;
        else if (CMD_WR)
            cmd_q <= CMD_WORD[cuod_pkg::CMD_BYTE_HI:cuod_pkg::CMD_BYTE_LO];
        else if (acc)
            cmd_q[cuod_pkg::FLD_HI:cuod_pkg::FLD_LO] <= cuod_pkg::OP_NOP;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            gp_q <= cuod_pkg::GP_RST;
        else if (GP_WR)
            gp_q <= GP_WDATA;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            base_q <= cuod_pkg::GP_RST;
        else if (acc && op == cuod_pkg::OP_LD_BASE)
            base_q <= gp_q;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            dump_addr_q <= cuod_pkg::GP_RST;
        else if (acc && op == cuod_pkg::OP_LD_DUMP)
            dump_addr_q <= gp_q;
    end

    // Unit state: list events first, an accepted start, or a resume while not idle, overrides them
    always_comb
    begin
        cu_d = cu_q;
        if (CB_IDLE)
            cu_d = cuod_pkg::CU_IDLE;
        else if (CB_SUSPEND)
            cu_d = cuod_pkg::CU_SUSP;
        if (acc)
        begin
            case (op)
                cuod_pkg::OP_START:
                    cu_d = cuod_pkg::CU_ACTIVE;
                cuod_pkg::OP_RESUME, cuod_pkg::OP_S_RESUME:
                begin
                    if (wake)
                        cu_d = cuod_pkg::CU_ACTIVE;
                end
                default:
                    cu_d = cu_d;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            cu_q <= cuod_pkg::CU_IDLE;
        else
            cu_q <= cu_d;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            start_q   <= 1'b0;
            resume_q  <= 1'b0;
            cb_addr_q <= cuod_pkg::GP_RST;
        end
        else
        begin
            start_q  <= acc && op == cuod_pkg::OP_START;
            resume_q <= acc && wake &&
                        (op == cuod_pkg::OP_RESUME || op == cuod_pkg::OP_S_RESUME);
            if (acc && op == cuod_pkg::OP_START)
                cb_addr_q <= gp_q;
        end
    end

    cuod_dump #(
        .N_CNT     (N_CNT),
        .W         (32)
    ) u_dump (
        .clk       (CLK),
        .rst       (RST),
        .start     (dump_go),
        .clr_after (op == cuod_pkg::OP_DUMP_CLR),
        .base      (dump_addr_q),
        .cnt_flat  (STAT_CNT),
        .mem_ready (MEM_READY),
        .busy      (dump_busy),
        .mem_valid (MEM_VALID),
        .mem_addr  (MEM_ADDR),
        .mem_wdata (MEM_WDATA),
        .cnt_clr   (STAT_CLR),
        .done      (DUMP_DONE)
    );

    assign CMD_BYTE  = cmd_q;
    assign GP_VALUE  = gp_q;
    assign CU_STATE  = cu_q;
    assign CB_START  = start_q;
    assign CB_RESUME = resume_q;
    assign CB_ADDR   = cb_addr_q;
    assign CU_BASE   = base_q;
    assign DUMP_ADDR = dump_addr_q;
    assign DUMP_BUSY = dump_busy;

    a_field_cleared: assert property (@(posedge CLK) disable iff (RST)
        (acc && !CMD_WR) |=> cmd_q[cuod_pkg::FLD_HI:cuod_pkg::FLD_LO] == cuod_pkg::OP_NOP)
        else $error("command field not cleared on acceptance");

    a_held_pending: assert property (@(posedge CLK) disable iff (RST)
        (dump_busy && op != cuod_pkg::OP_NOP && !CMD_WR) |=> $stable(cmd_q))
        else $error("command not held during dump");

    a_nop_quiet: assert property (@(posedge CLK) disable iff (RST)
        (op == cuod_pkg::OP_NOP && !CB_IDLE && !CB_SUSPEND)
        |=> $stable(cu_q) && !CB_START && !CB_RESUME)
        else $error("idle opcode changed the unit");

    a_start_active: assert property (@(posedge CLK) disable iff (RST)
        (acc && op == cuod_pkg::OP_START)
        |=> CB_START && cu_q == cuod_pkg::CU_ACTIVE && CB_ADDR == $past(gp_q) ##1 !CB_START)
        else $error("start did not launch the list");

    a_resume_idle_ignored: assert property (@(posedge CLK) disable iff (RST)
        (acc && op == cuod_pkg::OP_RESUME && cu_q == cuod_pkg::CU_IDLE && !CB_SUSPEND)
        |=> cu_q == cuod_pkg::CU_IDLE && !CB_RESUME)
        else $error("resume acted while idle");

    a_static_resume: assert property (@(posedge CLK) disable iff (RST)
        (acc && op == cuod_pkg::OP_S_RESUME)
        |=> CB_RESUME == ($past(cu_q) != cuod_pkg::CU_IDLE))
        else $error("static resume misbehaved");

    a_resume_susp: assert property (@(posedge CLK) disable iff (RST)
        (acc && op == cuod_pkg::OP_RESUME && cu_q == cuod_pkg::CU_SUSP)
        |=> CB_RESUME && cu_q == cuod_pkg::CU_ACTIVE)
        else $error("resume from suspend failed");

    a_dump_addr_load: assert property (@(posedge CLK) disable iff (RST)
        (acc && op == cuod_pkg::OP_LD_DUMP) |=> DUMP_ADDR == $past(gp_q))
        else $error("dump address not captured");

    a_base_load: assert property (@(posedge CLK) disable iff (RST)
        (acc && op == cuod_pkg::OP_LD_BASE) |=> CU_BASE == $past(gp_q))
        else $error("base register not loaded");

    a_dump_begins: assert property (@(posedge CLK) disable iff (RST)
        dump_go |=> DUMP_BUSY && MEM_VALID && MEM_ADDR == $past(dump_addr_q))
        else $error("dump did not start at dump address");

    a_undef_nop: assert property (@(posedge CLK) disable iff (RST)
        (acc && (op == 4'h3 || op == 4'h8 || op == 4'h9 || op > 4'ha) && !CB_IDLE && !CB_SUSPEND)
        |=> $stable(cu_q) && !CB_START && !CB_RESUME && !DUMP_BUSY)
        else $error("undefined opcode had an effect");

    c_start: cover property (@(posedge CLK) disable iff (RST)
        acc && op == cuod_pkg::OP_START);
    c_dump_clear: cover property (@(posedge CLK) disable iff (RST)
        STAT_CLR);
    c_static_from_susp: cover property (@(posedge CLK) disable iff (RST)
        acc && op == cuod_pkg::OP_S_RESUME && cu_q == cuod_pkg::CU_SUSP);
    c_cmd_held_by_dump: cover property (@(posedge CLK) disable iff (RST)
        dump_busy && op != cuod_pkg::OP_NOP);

endmodule // cuod_top
`default_nettype wire

// ---- rtl/cuod_pkg.sv ----
// Purpose: Shared constants and types for the command-unit opcode decoder
// Assumes: Single clock, synchronous active-high reset
// Notes:   Command byte holds bits 23:16 of the command word
package cuod_pkg;

    localparam int          GP_W        = 32;
    localparam int          CMD_BYTE_LO = 16;
    localparam int          CMD_BYTE_HI = 23;
    localparam int          CUC_LO      = 20;
    localparam int          CUC_HI      = 23;
    localparam int          FLD_LO      = CUC_LO - CMD_BYTE_LO;
    localparam int          FLD_HI      = CUC_HI - CMD_BYTE_LO;
    localparam int          RESV_BIT    = 19;
    localparam int          N_CNT_DEF   = 16;

    localparam logic [3:0]  OP_NOP      = 4'h0;
    localparam logic [3:0]  OP_START    = 4'h1;
    localparam logic [3:0]  OP_RESUME   = 4'h2;
    localparam logic [3:0]  OP_LD_DUMP  = 4'h4;
    localparam logic [3:0]  OP_DUMP     = 4'h5;
    localparam logic [3:0]  OP_LD_BASE  = 4'h6;
    localparam logic [3:0]  OP_DUMP_CLR = 4'h7;
    localparam logic [3:0]  OP_S_RESUME = 4'ha;

    localparam logic [7:0]  CMD_RST     = 8'h00;
    localparam logic [31:0] GP_RST      = 32'h0000_0000;
    localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;

    typedef enum logic [1:0] {
        CU_IDLE   = 2'b00,
        CU_SUSP   = 2'b01,
        CU_ACTIVE = 2'b10
    } cuod_cu_state_t;

    typedef enum logic [1:0] {
        D_IDLE  = 2'b00,
        D_WRITE = 2'b01,
        D_CLEAR = 2'b10
    } cuod_dump_state_t;

endpackage

// ---- rtl/cuod_dump.sv ----
// Purpose: Writes statistical counters to memory, optionally clears them
// Assumes: Memory sink accepts a word when mem_valid and mem_ready are high
// Notes:   Counters are read live, one word per accepted write
`timescale 1ns/1ps
`default_nettype none
module cuod_dump #(
    parameter int N_CNT = cuod_pkg::N_CNT_DEF,
    parameter int W     = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic             clr_after,
    input  wire logic [W-1:0]     base,
    input  wire logic [N_CNT*W-1:0] cnt_flat,
    input  wire logic             mem_ready,
    output logic                  busy,
    output logic                  mem_valid,
    output logic [W-1:0]          mem_addr,
    output logic [W-1:0]          mem_wdata,
    output logic                  cnt_clr,
    output logic                  done
);
    localparam int             IW   = (N_CNT > 1) ? $clog2(N_CNT) : 1;
    localparam logic [IW-1:0]  LAST = IW'(N_CNT - 1);

    cuod_pkg::cuod_dump_state_t state_q;
    logic [IW-1:0]              idx_q;
    logic [IW-1:0]              idx_nx;
    logic                       clr_q;
    logic [W-1:0]               cnt_arr [N_CNT];

    genvar g;
    generate
        for (g = 0; g < N_CNT; g++)
        begin : g_unpack
            assign cnt_arr[g] = cnt_flat[g*W +: W];
        end
    endgenerate

    assign idx_nx = idx_q + 1'b1;
    assign busy   = (state_q != cuod_pkg::D_IDLE);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q   <= cuod_pkg::D_IDLE;
            idx_q     <= '0;
            clr_q     <= 1'b0;
            mem_valid <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
            cnt_clr   <= 1'b0;
            done      <= 1'b0;
        end
        else
        begin
            cnt_clr <= 1'b0;
            done    <= 1'b0;
            case (state_q)
                cuod_pkg::D_IDLE:
                begin
                    if (start)
                    begin
                        state_q   <= cuod_pkg::D_WRITE;
                        idx_q     <= '0;
                        clr_q     <= clr_after;
                        mem_valid <= 1'b1;
                        mem_addr  <= base;
                        mem_wdata <= cnt_arr[0];
                    end
                end
                cuod_pkg::D_WRITE:
                begin
                    if (mem_ready)
                    begin
                        if (idx_q == LAST)
                        begin
                            mem_valid <= 1'b0;
                            // Clear only after the last word left, so no count is lost
                            if (clr_q)
                                state_q <= cuod_pkg::D_CLEAR;
                            else
                            begin
                                state_q <= cuod_pkg::D_IDLE;
                                done    <= 1'b1;
                            end
                        end
                        else
                        begin
                            idx_q     <= idx_nx;
                            mem_addr  <= mem_addr + cuod_pkg::WORD_BYTES;
                            mem_wdata <= cnt_arr[idx_nx];
                        end
                    end
                end
                cuod_pkg::D_CLEAR:
                begin
                    cnt_clr <= 1'b1;
                    done    <= 1'b1;
                    state_q <= cuod_pkg::D_IDLE;
                end
                default:
                begin
                    state_q <= cuod_pkg::D_IDLE;
                end
            endcase
        end
    end

    a_addr_step: assert property (@(posedge clk) disable iff (rst)
        (state_q == cuod_pkg::D_WRITE && mem_ready && idx_q != LAST)
        |=> mem_valid && mem_addr == $past(mem_addr) + cuod_pkg::WORD_BYTES)
        else $error("dump address did not step by one word");

    a_clear_after_dump: assert property (@(posedge clk) disable iff (rst)
        (state_q == cuod_pkg::D_WRITE && mem_ready && idx_q == LAST && clr_q)
        |=> !mem_valid ##1 (cnt_clr && done))
        else $error("counters not cleared right after dump");

    a_plain_no_clear: assert property (@(posedge clk) disable iff (rst)
        (state_q == cuod_pkg::D_WRITE && mem_ready && idx_q == LAST && !clr_q)
        |=> done && !cnt_clr && !busy)
        else $error("plain dump ended wrongly");

endmodule // cuod_dump
`default_nettype wire

// ---- dv/cuod_host.sv ----
// Purpose: Host software stand-in writing the pointer and the command byte
// Assumes: Drives 1 ns after the rising clock edge
// Notes:   Strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module cuod_host (
    input  wire logic   clk,
    output logic        cmd_wr,
    output logic [31:0] cmd_word,
    output logic        gp_wr,
    output logic [31:0] gp_wdata
);
    bit dump_loaded;

    initial
    begin
        cmd_wr      = 1'b0;
        cmd_word    = 32'h0000_0000;
        gp_wr       = 1'b0;
        gp_wdata    = 32'h0000_0000;
        dump_loaded = 1'b0;
    end

    task automatic load_gp(input logic [31:0] v);
        @(posedge clk);
        #1;
        gp_wr    = 1'b1;
        gp_wdata = v;
        @(posedge clk);
        #1;
        gp_wr    = 1'b0;
    endtask

    // Junk outside the command byte must be ignored
    task automatic issue(input logic [3:0] op, input logic [2:0] lo);
        @(posedge clk);
        #1;
        cmd_wr   = 1'b1;
        cmd_word = {8'ha5, op, 1'b0, lo, 16'hffff};
        @(posedge clk);
        #1;
        cmd_wr   = 1'b0;
    endtask

    // Caller starts only while not active
    task automatic start_list(input logic [31:0] a);
        load_gp(a);
        issue(4'h1, 3'h0);
    endtask

    task automatic set_dump(input logic [31:0] a);
        load_gp(a);
        issue(4'h4, 3'h0);
        dump_loaded = 1'b1;
    endtask

    // Software never dumps to an unset address
    task automatic dump(input logic [3:0] op);
        if (dump_loaded)
            issue(op, 3'h0);
    endtask
endmodule // cuod_host
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the command-unit opcode decoder
// Assumes: Two counters, ready toggling to stall the dump
// Notes:   Expected values come from opcode meanings only
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int          NC = 2;
    localparam logic [31:0] C0 = 32'h1111_2222;
    localparam logic [31:0] C1 = 32'h3333_4444;
    localparam logic [31:0] DA = 32'h0000_8000;

    logic          CLK, RST, CMD_WR, GP_WR, CB_SUSPEND, CB_IDLE, MEM_READY;
    logic [31:0]   CMD_WORD, GP_WDATA, GP_VALUE, CB_ADDR, CU_BASE, DUMP_ADDR;
    logic [31:0]   MEM_ADDR, MEM_WDATA;
    logic [NC*32-1:0] STAT_CNT;
    logic [7:0]    CMD_BYTE;
    logic [1:0]    CU_STATE;
    logic          CB_START, CB_RESUME, DUMP_BUSY, MEM_VALID, STAT_CLR, DUMP_DONE;
    int            errors, checked, cycles;

    cuod_top #(.N_CNT(NC)) cuod_top_i (.CLK(CLK), .RST(RST), .CMD_WR(CMD_WR), .CMD_WORD(CMD_WORD),
        .GP_WR(GP_WR), .GP_WDATA(GP_WDATA), .CB_SUSPEND(CB_SUSPEND), .CB_IDLE(CB_IDLE),
        .STAT_CNT(STAT_CNT), .MEM_READY(MEM_READY), .CMD_BYTE(CMD_BYTE), .GP_VALUE(GP_VALUE),
        .CU_STATE(CU_STATE), .CB_START(CB_START), .CB_RESUME(CB_RESUME), .CB_ADDR(CB_ADDR),
        .CU_BASE(CU_BASE), .DUMP_ADDR(DUMP_ADDR), .DUMP_BUSY(DUMP_BUSY), .MEM_VALID(MEM_VALID),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .STAT_CLR(STAT_CLR), .DUMP_DONE(DUMP_DONE));

    cuod_host cuod_host_i (.clk(CLK), .cmd_wr(CMD_WR), .cmd_word(CMD_WORD), .gp_wr(GP_WR),
        .gp_wdata(GP_WDATA));

    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok)
        begin
            errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    // One-cycle pulse from the execution engine
    task automatic ev(input bit idle);
        @(posedge CLK);
        #1;
        CB_IDLE    = idle;
        CB_SUSPEND = !idle;
        cyc(1);
        CB_IDLE    = 1'b0;
        CB_SUSPEND = 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_idle_ops;
        logic [3:0] ops [11] = '{4'h0, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
        foreach (ops[k])
        begin
            cuod_host_i.issue(ops[k], 3'h5);
            cyc(1);
            chk(CMD_BYTE === 8'h05, "opcode not cleared, low bits lost");
            chk(CU_STATE === 2'b00 && CB_RESUME === 1'b0 && CB_START === 1'b0, "idle op acted");
        end
    endtask

    task automatic t_start;
        cuod_host_i.start_list(32'h8765_4320);
        chk(CMD_BYTE[7:4] === 4'h1 && CB_START === 1'b0, "start too early");
        cyc(1);
        chk(CB_START === 1'b1 && CB_ADDR === 32'h8765_4320, "start pulse or address");
        chk(CU_STATE === 2'b10 && CMD_BYTE[7:4] === 4'h0, "start state or clear");
        cyc(1);
        chk(CB_START === 1'b0, "start pulse too long");
    endtask

    task automatic t_resume;
        ev(1'b0);
        chk(CU_STATE === 2'b01, "not suspended");
        cuod_host_i.issue(4'h2, 3'h0);
        cyc(1);
        chk(CB_RESUME === 1'b1 && CU_STATE === 2'b10, "resume");
        ev(1'b0);
        cuod_host_i.issue(4'ha, 3'h0);
        cyc(1);
        chk(CB_RESUME === 1'b1 && CU_STATE === 2'b10, "static resume");
        cyc(1);
        chk(CB_RESUME === 1'b0, "resume pulse too long");
        ev(1'b1);
        cuod_host_i.issue(4'h2, 3'h0);
        cyc(1);
        chk(CB_RESUME === 1'b0 && CU_STATE === 2'b00, "resume from idle acted");
    endtask

    task automatic t_loads;
        cuod_host_i.load_gp(32'hfedc_ba98);
        cuod_host_i.issue(4'h6, 3'h0);
        cyc(1);
        chk(CU_BASE === 32'hfedc_ba98 && GP_VALUE === 32'hfedc_ba98, "base load");
        cuod_host_i.set_dump(DA);
        cyc(1);
        chk(DUMP_ADDR === DA, "dump address load");
    endtask

    // Ready toggles so every word sees one stall cycle
    task automatic t_dump(input logic [3:0] op);
        int words;
        int clrs;
        int dones;
        words = 0;
        clrs  = 0;
        dones = 0;
        cuod_host_i.dump(op);
        for (int i = 0; i < 20; i++)
        begin
            cyc(1);
            MEM_READY = i[0];
            clrs += (STAT_CLR === 1'b1);
            dones += (DUMP_DONE === 1'b1);
            if (STAT_CLR === 1'b1)
                chk(words == NC, "clear before last word");
            if (MEM_VALID === 1'b1 && MEM_READY)
            begin
                chk(MEM_ADDR === DA + 4 * words && MEM_WDATA === (words == 0 ? C0 : C1), "dump word");
                words++;
            end
        end
        chk(words == NC && dones == 1 && clrs == int'(op == 4'h7) && DUMP_BUSY === 1'b0, "dump totals");
    endtask

    // Stalled dump keeps a later command pending in the byte
    task automatic t_hold;
        MEM_READY = 1'b0;
        cuod_host_i.load_gp(32'h0bad_0000);
        cuod_host_i.dump(4'h5);
        cuod_host_i.issue(4'h6, 3'h0);
        cyc(2);
        chk(CMD_BYTE[7:4] === 4'h6 && DUMP_BUSY === 1'b1, "command not held during dump");
        chk(CU_BASE === 32'hfedc_ba98, "held command acted early");
        MEM_READY = 1'b1;
        cyc(4);
        chk(CMD_BYTE[7:4] === 4'h0 && CU_BASE === 32'h0bad_0000, "held command lost");
    endtask

    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            $display("MISMATCH %0t timeout", $time);
            tally_and_finish();
        end
    end

    initial
    begin
        RST        = 1'b1;
        CB_SUSPEND = 1'b0;
        CB_IDLE    = 1'b0;
        MEM_READY  = 1'b0;
        STAT_CNT   = {C1, C0};
        cyc(3);
        RST = 1'b0;
        chk(CMD_BYTE === 8'h00 && CU_STATE === 2'b00 && CB_ADDR === 32'h0000_0000, "reset values");
        t_idle_ops();
        t_start();
        t_resume();
        t_loads();
        t_dump(4'h5);
        t_dump(4'h7);
        t_hold();
        RST = 1'b1;
        cyc(1);
        RST = 1'b0;
        chk(CU_STATE === 2'b00 && CU_BASE === 32'h0000_0000, "second reset");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
